// ### tx_line_pkg.sv
// Shared types and constants for the transmit line encoder path
package tx_line_pkg;

  // ****************************************
  // Widths, depths and code constants
  // ****************************************
  localparam int RAIL_W        = 2;    // Positive and negative rail per word
  localparam int FIFO_DEPTH    = 16;   // Words of elastic buffering
  localparam int LOOK_DEPTH    = 4;    // Look-ahead window, covers longest run
  localparam int B3ZS_RUN      = 3;    // Zero run replaced in B3ZS
  localparam int HDB3_RUN      = 4;    // Zero run replaced in HDB3
  localparam int PER_W         = 8;    // Width of line clock period counters
  localparam int CLK_PERIOD_NS = 100;  // mclk period
  localparam int DUTY_MIN_PCT  = 30;   // Least accepted line clock duty
  localparam int DUTY_MAX_PCT  = 70;   // Largest accepted line clock duty
  localparam int PCT_FULL      = 100;  // Percent scale

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic LAST_POS_RST = 1'b0;  // First mark goes out positive
  localparam logic PARITY_RST   = 1'b0;  // No marks since a violation

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    RATE_E3   = 2'h0,
    RATE_DS3  = 2'h1,
    RATE_STS1 = 2'h2
  } line_rate_e;

  typedef enum logic [1:0] {
    SYM_ZERO = 2'h0,
    SYM_MARK = 2'h1,
    SYM_VIOL = 2'h2,
    SYM_RAW  = 2'h3
  } sym_kind_e;

  typedef enum logic [1:0] {
    DC_IDLE    = 2'b00,
    DC_MEASURE = 2'b01,
    DC_RUN     = 2'b11
  } duty_state_e;

  typedef struct packed {
    logic pos;
    logic neg;
  } rail_s;

  typedef struct packed {
    sym_kind_e kind;
    rail_s     raw;
  } slot_s;

endpackage : tx_line_pkg

// ### tx_line_encoder_path.sv
// Transmit rail buffer, B3ZS/HDB3 encoder and shaper control
// Contract
// - Single-rail NRZ is used when the format pin is high in hardware mode or bit 0 is 1 in host mode.
// - Dual-rail is used when the format pin is low in hardware mode or bit 0 is 0 in host mode.
// - In dual-rail the positive input carries positive marks and the negative input negative marks.
// - Single-rail data is coded B3ZS at DS3 or STS-1 rate and HDB3 at E3 rate.
// - B3ZS replaces each three zeros by B0V or 00V keeping an odd mark count between violations.
// - HDB3 replaces each four zeros by 000V or B00V keeping an odd mark count between violations.
// - Dual-rail bypasses the encoder with no separate enable.
// - In dual-rail an incoming bipolar violation is sent on as an ordinary mark.
// - Build-out is off when the level pin or bit is 1 and on when it is 0.
// - At E3 rate build-out stays off whatever the level pin or bit says.
// - A line clock of 30% to 70% duty is accepted and regenerated at 50% for the shaper.
`timescale 1ns/1ns

// ****************************************
// Rail word FIFO
// ****************************************
module tx_rail_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Filling side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Draining side
  output logic                  out_valid,
  output logic      [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  // Full and empty from pointer difference
  assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data  = mem[rd_ptr[AW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_ready & out_valid;

  // Storage
  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end

  // Pointers
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule : tx_rail_fifo

// ****************************************
// Encoder path top
// ****************************************
module tx_line_encoder_path (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst,
  // Framer side
  input  wire logic                   transmit_line_clock,
  input  wire logic                   positive_tx_input,
  input  wire logic                   negative_tx_input,
  output logic                        input_ready,
  // Configuration
  input  wire logic                   host_mode,
  input  wire logic                   rail_format_select,
  input  wire logic                   rail_format_bit,
  input  wire logic                   build_out_level,
  input  wire logic                   build_out_bit,
  input  wire tx_line_pkg::line_rate_e line_rate,
  // Pulse shaper side
  input  wire logic                   shaper_ready,
  output logic                        shaper_strobe,
  output tx_line_pkg::rail_s          shaper_rail,
  output logic                        shaper_clock,
  output logic                        build_out_enable,
  output logic                        duty_error
);
  import tx_line_pkg::*;

  logic                  clk_d;
  logic                  line_edge;
  logic                  single_rail;
  logic                  is_e3;
  logic [2:0]            run_len;
  rail_s                 in_word;
  rail_s                 fifo_word;
  logic                  fifo_valid;
  logic                  advance;
  slot_s                 in_slot;
  slot_s                 win      [LOOK_DEPTH];
  slot_s                 next_win [LOOK_DEPTH];
  slot_s                 out_slot;
  logic                  zero_run;
  logic                  sub_par;
  logic                  last_pos;
  logic                  parity;
  duty_state_e           dstate;
  logic [PER_W-1:0]      cnt;
  logic [PER_W-1:0]      hi_cnt;
  logic [PER_W-1:0]      period;
  logic [PER_W-1:0]      next_cnt;

  // ****************************************
  // Mode decode
  // ****************************************
  assign single_rail = host_mode ? rail_format_bit : rail_format_select;
  assign is_e3       = line_rate == RATE_E3;
  assign run_len     = is_e3 ? 3'(HDB3_RUN) : 3'(B3ZS_RUN);

  // Build-out control
  always_ff @(posedge mclk)
  begin
    if (rst)
      build_out_enable <= 1'b0;
    else
      build_out_enable <= ~(host_mode ? build_out_bit : build_out_level)
                          & ~is_e3;
  end

  // ****************************************
  // Line clock edge and input capture
  // ****************************************
  // Previous pin sample, kept through reset so a high pin gives no false edge
  always_ff @(posedge mclk)
  begin
    clk_d <= transmit_line_clock;
  end

  assign line_edge = transmit_line_clock & ~clk_d;
  assign in_word   = '{pos: positive_tx_input, neg: negative_tx_input};
  assign advance   = line_edge & fifo_valid & shaper_ready;

  tx_rail_fifo #(
    .WIDTH (RAIL_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (line_edge),
    .in_data   (in_word),
    .in_ready  (input_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_word),
    .out_ready (advance)
  );

  // ****************************************
  // Look-ahead window and substitution
  // ****************************************
  // Single-rail uses the positive rail only; dual-rail passes raw rails
  always_comb
  begin
    in_slot.raw  = fifo_word;
    if (single_rail)
      in_slot.kind = fifo_word.pos ? SYM_MARK : SYM_ZERO;
    else
      in_slot.kind = SYM_RAW;
  end

  // Zero run detection and parity at the substitution point
  always_comb
  begin
    zero_run = single_rail && (in_slot.kind == SYM_ZERO);
    sub_par  = parity;
    for (int j = LOOK_DEPTH - 1; j >= 0; j--)
    begin
      if (j >= int'(run_len) - 1)
      begin
        if (win[j].kind == SYM_VIOL)
          sub_par = 1'b0;
        else if (win[j].kind == SYM_MARK)
          sub_par = ~sub_par;
      end
      if (j < int'(run_len) - 1 && win[j].kind != SYM_ZERO)
        zero_run = 1'b0;
    end
  end

  // Shift stages with in-place rewrite of a detected run
  for (genvar i = 0; i < LOOK_DEPTH; i++)
  begin : g_win
    always_comb
    begin
      next_win[i] = (i == 0) ? in_slot : win[(i == 0) ? 0 : i - 1];
      if (zero_run)
      begin
        if (i == 0)
          next_win[i].kind = SYM_VIOL;
        else if (i == int'(run_len) - 1)
          next_win[i].kind = sub_par ? SYM_ZERO : SYM_MARK;
      end
    end

    always_ff @(posedge mclk)
    begin
      if (rst)
        win[i] <= '{kind: SYM_ZERO, raw: '0};
      else if (advance)
        win[i] <= next_win[i];
    end
  end

  assign out_slot = win[LOOK_DEPTH-1];

  // ****************************************
  // Polarity and parity tracking
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      last_pos <= LAST_POS_RST;
      parity   <= PARITY_RST;
    end
    else if (advance)
    begin
      case (out_slot.kind)
        SYM_MARK:
        begin
          last_pos <= ~last_pos;
          parity   <= ~parity;
        end
        SYM_VIOL:
          parity <= 1'b0;
        default:
          parity <= parity;
      endcase
    end
  end

  // Output rails to the shaper
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      shaper_strobe <= 1'b0;
      shaper_rail   <= '0;
    end
    else
    begin
      shaper_strobe <= advance;
      if (advance)
      begin
        case (out_slot.kind)
          SYM_MARK: shaper_rail <= '{pos: ~last_pos, neg: last_pos};
          SYM_VIOL: shaper_rail <= '{pos: last_pos, neg: ~last_pos};
          SYM_RAW:  shaper_rail <= '{pos: out_slot.raw.pos,
                                     neg: out_slot.raw.neg & ~out_slot.raw.pos};
          default:  shaper_rail <= '0;
        endcase
      end
    end
  end

  // ****************************************
  // Line clock duty correction
  // ****************************************
  assign next_cnt = line_edge ? '0 : cnt + 1'b1;

  // Period and high time measurement
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      dstate <= DC_IDLE;
      cnt    <= '0;
      hi_cnt <= '0;
      period <= '0;
    end
    else
    begin
      cnt <= next_cnt;
      if (line_edge)
      begin
        period <= cnt + 1'b1;
        hi_cnt <= '0;
      end
      else if (clk_d)
        hi_cnt <= hi_cnt + 1'b1;
      case (dstate)
        DC_IDLE:    dstate <= line_edge ? DC_MEASURE : DC_IDLE;
        DC_MEASURE: dstate <= line_edge ? DC_RUN : DC_MEASURE;
        DC_RUN:     dstate <= DC_RUN;
        default:    dstate <= DC_IDLE;
      endcase
    end
  end

  // Regenerated 50% clock and duty range flag
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      shaper_clock <= 1'b0;
      duty_error   <= 1'b0;
    end
    else
    begin
      shaper_clock <= (dstate == DC_RUN) && (next_cnt < (period >> 1));
      if (line_edge && dstate != DC_IDLE)
        duty_error <= (16'(hi_cnt) * 16'(PCT_FULL) < 16'(cnt + 1'b1) * 16'(DUTY_MIN_PCT))
                   || (16'(hi_cnt) * 16'(PCT_FULL) > 16'(cnt + 1'b1) * 16'(DUTY_MAX_PCT));
    end
  end
endmodule : tx_line_encoder_path

// ### tx_line_asserts.sv
// Port checker for the encoder path
`timescale 1ns/1ns
module tx_line_asserts (
  // Clock and reset
  input wire logic                    mclk,
  input wire logic                    rst,
  // Watched ports
  input wire logic                    transmit_line_clock,
  input wire logic                    host_mode,
  input wire logic                    build_out_level,
  input wire logic                    build_out_bit,
  input wire tx_line_pkg::line_rate_e line_rate,
  input wire logic                    shaper_ready,
  input wire logic                    shaper_strobe,
  input wire tx_line_pkg::rail_s      shaper_rail,
  input wire logic                    build_out_enable,
  input wire logic                    duty_error
);
  import tx_line_pkg::*;
  // ****************
  // Properties
  // ****************
  logic want_bo;
  // Build-out wanted by the present inputs
  assign want_bo = !(host_mode ? build_out_bit : build_out_level) && line_rate != RATE_E3;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // One line clock cycle at half duty
  sequence s_half;
    transmit_line_clock [*2] ##1 !transmit_line_clock [*2];
  endsequence
  AST_STROBE_PULSE: assert property (shaper_strobe |=> !shaper_strobe)
    else $error("strobe too long");
  AST_RAIL_HOLD: assert property (!shaper_strobe && !$past(rst) |-> $stable(shaper_rail))
    else $error("rail moved without strobe");
  AST_STROBE_CAUSE: assert property (shaper_strobe |-> $past(shaper_ready)
    && $past(transmit_line_clock) && !$past(transmit_line_clock, 2))
    else $error("strobe without advance");
  AST_BUILD_OUT: assert property (!rst |=> build_out_enable == $past(want_bo))
    else $error("build-out wrong");
  AST_E3_OFF: assert property (line_rate == RATE_E3 |=> !build_out_enable)
    else $error("build-out on at E3");
  AST_ONE_RAIL: assert property (!(shaper_rail.pos && shaper_rail.neg))
    else $error("both rails high");
  AST_DUTY_MOVE: assert property ($changed(duty_error) && !$past(rst) |->
    $past(transmit_line_clock) && !$past(transmit_line_clock, 2))
    else $error("duty flag off edge");
  AST_DUTY_HALF: assert property (!transmit_line_clock ##1 s_half ##1 s_half
    ##1 transmit_line_clock |=> !duty_error)
    else $error("half duty flagged");
endmodule : tx_line_asserts

bind tx_line_encoder_path tx_line_asserts u_tx_line_asserts (
  .mclk(mclk), .rst(rst), .transmit_line_clock(transmit_line_clock),
  .host_mode(host_mode), .build_out_level(build_out_level),
  .build_out_bit(build_out_bit), .line_rate(line_rate), .shaper_ready(shaper_ready),
  .shaper_strobe(shaper_strobe), .shaper_rail(shaper_rail),
  .build_out_enable(build_out_enable), .duty_error(duty_error)
);

// ### tx_framer_model.sv
// Framer model driving the line clock and rails
`timescale 1ns/1ns
module tx_framer_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Line clock shape and format
  input  wire logic [7:0] per,
  input  wire logic [7:0] hi,
  input  wire logic       single,
  // Framer outputs
  output logic            lclk = 1'b0,
  output logic            pos = 1'b0,
  output logic            neg = 1'b0
);
  // ****************
  // Line clock and data
  // ****************
  logic [7:0] cnt = 8'h00;
  // Scaled line clock, high for hi of per cycles
  always @(posedge mclk)
  begin
    cnt <= (rst || cnt >= per - 8'h01) ? 8'h00 : cnt + 8'h01;
    lclk <= !rst && cnt < hi;
  end
  // New word at the rise, inverted once held; negative grounded in single-rail
  always @(posedge mclk)
  begin
    pos <= (cnt == 8'h00) ? $urandom_range(2) == 0 : !pos;
    neg <= !single && ((cnt == 8'h00) ? $urandom_range(2) == 0 : !neg);
  end
endmodule : tx_framer_model

// ### tb_top.sv
// Self-checking bench for the encoder path
`timescale 1ns/1ns
module tb_top;
  import tx_line_pkg::*;
  // ****************
  // Bench
  // ****************
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic host_mode = 1'b0;
  logic rail_format_select = 1'b0;
  logic rail_format_bit = 1'b0;
  logic build_out_level = 1'b0;
  logic build_out_bit = 1'b0;
  logic shaper_ready = 1'b1;
  logic single = 1'b0;
  line_rate_e line_rate = RATE_DS3;
  logic [7:0] hi = 8'h02;
  logic [7:0] per = 8'h04;
  logic lclk, pos, neg, prev, input_ready, shaper_strobe, shaper_clock;
  logic build_out_enable, duty_error, bo_w, lp;
  logic [1:0] w;
  rail_s shaper_rail;
  logic [1:0] q[$];
  byte dh[5] = '{2, 3, 5, 7, 8};
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  int zrun, zmax, nb, np, hv, bo_ok, hc;
  tx_framer_model u_tx_framer_model (
    .mclk(mclk), .rst(rst), .per(per), .hi(hi), .single(single),
    .lclk(lclk), .pos(pos), .neg(neg)
  );
  tx_line_encoder_path u_tx_line_encoder_path (
    .mclk(mclk), .rst(rst), .transmit_line_clock(lclk),
    .positive_tx_input(pos), .negative_tx_input(neg), .input_ready(input_ready),
    .host_mode(host_mode), .rail_format_select(rail_format_select),
    .rail_format_bit(rail_format_bit), .build_out_level(build_out_level),
    .build_out_bit(build_out_bit), .line_rate(line_rate),
    .shaper_ready(shaper_ready), .shaper_strobe(shaper_strobe),
    .shaper_rail(shaper_rail), .shaper_clock(shaper_clock),
    .build_out_enable(build_out_enable), .duty_error(duty_error)
  );
  always #50 mclk = ~mclk;
  function automatic logic want_bo();
    return !(host_mode ? build_out_bit : build_out_level) && line_rate != RATE_E3;
  endfunction : want_bo
  function automatic logic [1:0] exp_rail(logic [1:0] v);
    return {v[1], v[0] & !v[1]};
  endfunction : exp_rail
  task automatic check(string n, logic [1:0] s, logic [1:0] e);
    checks_done++;
    if (s !== e)
    begin
      $display("BAD %s exp %h seen %h", n, e, s);
      err_count++;
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test
  // One mode segment; the unselected format control always disagrees
  task automatic seg(logic hm, logic fmt, line_rate_e r, int n);
    host_mode <= hm;
    rail_format_select <= hm ^ fmt;
    rail_format_bit <= !(hm ^ fmt);
    line_rate <= r;
    single <= fmt;
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    repeat (n)
    begin
      @(posedge mclk);
      shaper_ready <= $urandom_range(3) != 0;
      build_out_level <= $urandom_range(1);
      build_out_bit <= $urandom_range(1);
    end
    if (fmt && r == RATE_E3) check("hdb3", 2'(zmax), 2'h3);
  endtask : seg
  // Word tracker and symbol checks
  always @(posedge mclk)
  begin
    prev <= lclk;
    if (rst)
    begin
      q = '{2'h0, 2'h0, 2'h0, 2'h0};
      {zrun, zmax, nb, np, hv, bo_ok} = 0;
    end
    else
    begin
      if (bo_ok) check("bo", 2'(build_out_enable), 2'(bo_w));
      bo_w = want_bo();
      bo_ok = 1;
      if (lclk && !prev && input_ready) q.push_back({pos, neg});
      if (shaper_strobe && q.size() > 0)
      begin
        w = q.pop_front();
        if (!single) check("rail", shaper_rail, exp_rail(w));
        else if (w[1]) check("mark", {^shaper_rail, !np || shaper_rail.pos != lp}, 2'h3);
        if (single && (shaper_rail.pos || shaper_rail.neg))
        begin
          if (np == 0) check("first", shaper_rail, 2'h2);
          if (np > 0 && shaper_rail.pos == lp)
          begin
            if (hv) check("odd", 2'(nb[0]), 2'h1);
            {hv, nb} = 64'h1_0000_0000;
          end
          else nb++;
          lp = shaper_rail.pos;
          np++;
          zrun = 0;
        end
        else if (single)
        begin
          zrun++;
          zmax = zrun > zmax ? zrun : zmax;
          check("zrun", 2'(zrun < (line_rate == RATE_E3 ? 4 : 3)), 2'h1);
        end
      end
    end
  end
  // Hang guard
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      err_count++;
      finish_test();
    end
  end
  initial
  begin
    void'($urandom(32'h388b7210));
    repeat (2) @(posedge mclk);
    for (int k = 0; k < 7; k++) seg(k[0], k > 1, line_rate_e'(k % 3), 400);
    seg(1'b0, 1'b0, RATE_DS3, 0);
    shaper_ready <= 1'b0;
    repeat (100) @(posedge mclk);
    check("full", 2'(input_ready), 2'h0);
    shaper_ready <= 1'b1;
    repeat (200) @(posedge mclk);
    check("drain", 2'(input_ready), 2'h1);
    per <= 8'h0a;
    foreach (dh[i])
    begin
      hi <= 8'(dh[i]);
      hc = 0;
      repeat (40) @(posedge mclk) hc += shaper_clock;
      check("duty", 2'(duty_error), 2'(dh[i] < 3 || dh[i] > 7));
      if (i == 2) check("sclk", 2'(hc == 20), 2'h1);
    end
    finish_test();
  end
endmodule : tb_top
